/* File: compare_pkg.sv */
/*
 * Shared constants and types for the compare pin output control block.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
package compare_pkg;

   localparam int ADDR_WIDTH = 12;
   localparam int DATA_WIDTH = 32;
   localparam int IDX_WIDTH  = 10;
   localparam int CMP_WIDTH  = 16;
   localparam int NUM_CH     = 4;

   // Register indices; byte address is four times the index
   localparam logic [IDX_WIDTH-1:0] CTRL_AB_IDX = 10'h124;
   localparam logic [IDX_WIDTH-1:0] CTRL_CD_IDX = 10'h125;
   localparam logic [IDX_WIDTH-1:0] CMP_A_IDX   = 10'h128;
   localparam logic [IDX_WIDTH-1:0] CMP_B_IDX   = 10'h129;
   localparam logic [IDX_WIDTH-1:0] CMP_C_IDX   = 10'h12A;
   localparam logic [IDX_WIDTH-1:0] CMP_D_IDX   = 10'h12B;
   localparam logic [IDX_WIDTH-1:0] MODE_IDX    = 10'h12C;
   localparam logic [IDX_WIDTH-1:0] STATUS_IDX  = 10'h12D;

   // Reset values
   localparam logic [6:0]           CTRL_AB_RESET = 7'h08;
   localparam logic                 CTRL_AB_FILL  = 1'h1;
   localparam logic [7:0]           CTRL_CD_RESET = 8'h88;
   localparam logic [CMP_WIDTH-1:0] CMP_RESET     = 16'h0000;
   localparam logic [1:0]           MODE_RESET    = 2'h0;

   // Field positions in the mode register
   localparam int BUF_SEL_C_BIT = 0;
   localparam int BUF_SEL_D_BIT = 1;

   // Channel indices
   localparam int CH_A = 0;
   localparam int CH_B = 1;
   localparam int CH_C = 2;
   localparam int CH_D = 3;

   typedef enum logic [1:0] {
      ACT_NONE   = 2'b00,
      ACT_LOW    = 2'b01,
      ACT_HIGH   = 2'b10,
      ACT_TOGGLE = 2'b11
   } pin_action_t;

   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_ACK  = 1'b1
   } bus_state_t;

   // Stored bits 6..0 of the first control register
   typedef struct packed {
      logic        mode_sel_b;
      pin_action_t pin_action_b;
      logic        capture_switch_a;
      logic        mode_sel_a;
      pin_action_t pin_action_a;
   } ctrl_ab_t;

   typedef struct packed {
      logic        route_sel_d;
      logic        mode_sel_d;
      pin_action_t pin_action_d;
      logic        route_sel_c;
      logic        mode_sel_c;
      pin_action_t pin_action_c;
   } ctrl_cd_t;

   typedef struct packed {
      logic                  read;
      logic                  write;
      logic [ADDR_WIDTH-1:0] address;
      logic [DATA_WIDTH-1:0] writedata;
      logic [3:0]            byteenable;
   } avmm_req_t;

endpackage

/* File: pin_action_unit.sv */
/*
 * One compare output pin: level and enable flip-flops.
 * Assumes match strobes and action codes are decoded by the caller.
 */
module pin_action_unit (
   input  wire logic                     sys_clk_in,
   input  wire logic                     rst_b_in,
   input  wire logic                     match_pri_in,
   input  wire compare_pkg::pin_action_t code_pri_in,
   input  wire logic                     match_sec_in,
   input  wire compare_pkg::pin_action_t code_sec_in,
   input  wire logic                     drive_en_in,
   output logic                          level_out,
   output logic                          oe_out
);

   logic                     hit;
   compare_pkg::pin_action_t code;

   // Primary compare with a code other than ACT_NONE wins a coincident match
   always_comb begin
      hit  = 1'b0;
      code = compare_pkg::ACT_NONE;
      if (match_pri_in && code_pri_in != compare_pkg::ACT_NONE) begin
         hit  = 1'b1;
         code = code_pri_in;
      end else if (match_sec_in && code_sec_in != compare_pkg::ACT_NONE) begin
         hit  = 1'b1;
         code = code_sec_in;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         level_out <= 1'b0;
      end else if (hit) begin
         case (code)
            compare_pkg::ACT_LOW:    level_out <= 1'b0;
            compare_pkg::ACT_HIGH:   level_out <= 1'b1;
            compare_pkg::ACT_TOGGLE: level_out <= ~level_out; // [R16]
            default:                 level_out <= level_out;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         oe_out <= 1'b0;
      end else begin
         oe_out <= drive_en_in;
      end
   end

endmodule // pin_action_unit

/* File: compare_match_pin_output_control.sv */
/*
 * Compare match pin output control with Avalon-MM register access.
 * Assumes the counter value arrives synchronous to sys_clk_in, one count per clock.
 */
// Summary of operation
// [R1] Field A code: 00 none, 01 low, 10 high, 11 toggle pin A.
// [R2] Field B code acts on pin B the same way.
// [R3] Field C code acts on its pin the same way on a C match.
// [R4] Field D code acts on its pin the same way on a D match.
// [R5] Software keeps all four mode-select bits at 0 for compare use.
// [R6] Software keeps the capture switch bit of channel A at 1.
// [R7] Bit 3 of second control register routes C to pin A when 0.
// [R8] Bit 7 of second control register routes D to pin B when 0.
// [R9] In buffer mode software copies A's mode-select into C's.
// [R10] In buffer mode software copies B's mode-select into D's.
// [R11] Bit 7 of first control register reads 1; software writes 0.
// [R12] Reset clears action and mode bits; bits 3 and 7 read 1.
// [R13] Route bit at 0 makes C drive pin A, D drive pin B.
// [R14] Routed pin A follows A and C matches; pin B follows B and D.
// [R15] Buffer mode: C and D hold next compare values for A and B.
// [R16] Action lands on the match cycle edge; toggle inverts current level.
module compare_match_pin_output_control (
   input  wire logic                                sys_clk_in,
   input  wire logic                                rst_b_in,
   input  wire compare_pkg::avmm_req_t              avmm_req_in,
   output logic [compare_pkg::DATA_WIDTH-1:0]       avmm_readdata_out,
   output logic                                     avmm_waitrequest_out,
   input  wire logic [compare_pkg::CMP_WIDTH-1:0]   count_value_in,
   input  wire logic                                count_en_in,
   output logic                                     compare_pin_a_out,
   output logic                                     compare_pin_a_oe_out,
   output logic                                     compare_pin_b_out,
   output logic                                     compare_pin_b_oe_out,
   output logic                                     compare_pin_c_out,
   output logic                                     compare_pin_c_oe_out,
   output logic                                     compare_pin_d_out,
   output logic                                     compare_pin_d_oe_out
);

   localparam int NCH = compare_pkg::NUM_CH;
   localparam int CW  = compare_pkg::CMP_WIDTH;

   compare_pkg::ctrl_ab_t   ctrl_ab_r;
   compare_pkg::ctrl_cd_t   ctrl_cd_r;
   logic [1:0]              timer_mode_r;
   logic [CW-1:0]           cmp_r [NCH];
   compare_pkg::bus_state_t bus_state_r;
   logic [compare_pkg::DATA_WIDTH-1:0] rd_nxt;
   logic [compare_pkg::IDX_WIDTH-1:0]  idx;
   logic                    wr_go;
   logic                    buffer_sel_c;
   logic                    buffer_sel_d;
   logic                    route_c_to_a;
   logic                    route_d_to_b;
   logic                    own_c;
   logic                    own_d;
   logic [NCH-1:0]          match;
   logic [NCH-1:0]          match_pri;
   logic [NCH-1:0]          match_sec;
   compare_pkg::pin_action_t code_pri [NCH];
   compare_pkg::pin_action_t code_sec [NCH];
   logic [NCH-1:0]          drive_en;
   logic [NCH-1:0]          level;
   logic [NCH-1:0]          oe;
   logic [NCH-1:0]          mode_sel;

   assign idx          = avmm_req_in.address[compare_pkg::ADDR_WIDTH-1:2];
   assign wr_go        = bus_state_r == compare_pkg::BUS_ACK && avmm_req_in.write;
   assign buffer_sel_c = timer_mode_r[compare_pkg::BUF_SEL_C_BIT];
   assign buffer_sel_d = timer_mode_r[compare_pkg::BUF_SEL_D_BIT];
   assign route_c_to_a = !ctrl_cd_r.route_sel_c && !buffer_sel_c; // [R7] [R13]
   assign route_d_to_b = !ctrl_cd_r.route_sel_d && !buffer_sel_d; // [R8] [R13]
   assign own_c        = ctrl_cd_r.route_sel_c && !buffer_sel_c;
   assign own_d        = ctrl_cd_r.route_sel_d && !buffer_sel_d;
   assign mode_sel     = {ctrl_cd_r.mode_sel_d, ctrl_cd_r.mode_sel_c,
                          ctrl_ab_r.mode_sel_b, ctrl_ab_r.mode_sel_a};

   // Bus slave: request seen, then one cycle with waitrequest low
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         bus_state_r          <= compare_pkg::BUS_IDLE;
         avmm_waitrequest_out <= 1'b1;
      end else begin
         case (bus_state_r)
            compare_pkg::BUS_IDLE: begin
               if (avmm_req_in.read || avmm_req_in.write) begin
                  bus_state_r          <= compare_pkg::BUS_ACK;
                  avmm_waitrequest_out <= 1'b0;
               end
            end
            compare_pkg::BUS_ACK: begin
               bus_state_r          <= compare_pkg::BUS_IDLE;
               avmm_waitrequest_out <= 1'b1;
            end
            default: begin
               bus_state_r          <= compare_pkg::BUS_IDLE;
               avmm_waitrequest_out <= 1'b1;
            end
         endcase
      end
   end

   // Read mux; unmapped reads return zero
   always_comb begin
      rd_nxt = '0;
      case (idx)
         compare_pkg::CTRL_AB_IDX: rd_nxt[7:0] = {compare_pkg::CTRL_AB_FILL, ctrl_ab_r}; // [R11]
         compare_pkg::CTRL_CD_IDX: rd_nxt[7:0] = ctrl_cd_r;
         compare_pkg::CMP_A_IDX:   rd_nxt[CW-1:0] = cmp_r[compare_pkg::CH_A];
         compare_pkg::CMP_B_IDX:   rd_nxt[CW-1:0] = cmp_r[compare_pkg::CH_B];
         compare_pkg::CMP_C_IDX:   rd_nxt[CW-1:0] = cmp_r[compare_pkg::CH_C];
         compare_pkg::CMP_D_IDX:   rd_nxt[CW-1:0] = cmp_r[compare_pkg::CH_D];
         compare_pkg::MODE_IDX:    rd_nxt[1:0] = timer_mode_r;
         compare_pkg::STATUS_IDX:  rd_nxt[7:0] = {oe, level};
         default:                  rd_nxt = '0;
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         avmm_readdata_out <= '0;
      end else if (bus_state_r == compare_pkg::BUS_IDLE && avmm_req_in.read) begin
         avmm_readdata_out <= rd_nxt;
      end
   end

   // Control registers
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ctrl_ab_r    <= compare_pkg::CTRL_AB_RESET; // [R12]
         ctrl_cd_r    <= compare_pkg::CTRL_CD_RESET; // [R12]
         timer_mode_r <= compare_pkg::MODE_RESET;
      end else if (wr_go && avmm_req_in.byteenable[0]) begin
         case (idx)
            compare_pkg::CTRL_AB_IDX: ctrl_ab_r <= avmm_req_in.writedata[6:0]; // [R11]
            compare_pkg::CTRL_CD_IDX: ctrl_cd_r <= avmm_req_in.writedata[7:0];
            compare_pkg::MODE_IDX:    timer_mode_r <= avmm_req_in.writedata[1:0];
            default:                  ctrl_ab_r <= ctrl_ab_r;
         endcase
      end
   end

   // Compare values; buffer transfer on a primary match wins over a write
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int i = 0; i < NCH; i++) begin
            cmp_r[i] <= compare_pkg::CMP_RESET;
         end
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (wr_go && idx == compare_pkg::CMP_A_IDX + idx_cast(i)) begin
               if (avmm_req_in.byteenable[0]) begin
                  cmp_r[i][7:0] <= avmm_req_in.writedata[7:0];
               end
               if (avmm_req_in.byteenable[1]) begin
                  cmp_r[i][CW-1:8] <= avmm_req_in.writedata[CW-1:8];
               end
            end
         end
         if (buffer_sel_c && match[compare_pkg::CH_A]) begin
            cmp_r[compare_pkg::CH_A] <= cmp_r[compare_pkg::CH_C]; // [R15]
         end
         if (buffer_sel_d && match[compare_pkg::CH_B]) begin
            cmp_r[compare_pkg::CH_B] <= cmp_r[compare_pkg::CH_D]; // [R15]
         end
      end
   end

   function automatic logic [compare_pkg::IDX_WIDTH-1:0] idx_cast(input int v);
      idx_cast = v[compare_pkg::IDX_WIDTH-1:0];
   endfunction

   // Match detection; capture-mode channels and buffers never match
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         match[i] = count_en_in && count_value_in == cmp_r[i] && !mode_sel[i]; // [R16]
      end
      if (buffer_sel_c) begin
         match[compare_pkg::CH_C] = 1'b0; // [R15]
      end
      if (buffer_sel_d) begin
         match[compare_pkg::CH_D] = 1'b0; // [R15]
      end
   end

   // Per-pin steering of match strobes and action codes
   always_comb begin
      match_pri = '0;
      match_sec = '0;
      for (int i = 0; i < NCH; i++) begin
         code_pri[i] = compare_pkg::ACT_NONE;
         code_sec[i] = compare_pkg::ACT_NONE;
      end
      match_pri[compare_pkg::CH_A] = match[compare_pkg::CH_A];
      code_pri[compare_pkg::CH_A]  = ctrl_ab_r.pin_action_a; // [R1]
      match_sec[compare_pkg::CH_A] = match[compare_pkg::CH_C] && route_c_to_a; // [R14]
      code_sec[compare_pkg::CH_A]  = ctrl_cd_r.pin_action_c;
      match_pri[compare_pkg::CH_B] = match[compare_pkg::CH_B];
      code_pri[compare_pkg::CH_B]  = ctrl_ab_r.pin_action_b; // [R2]
      match_sec[compare_pkg::CH_B] = match[compare_pkg::CH_D] && route_d_to_b; // [R14]
      code_sec[compare_pkg::CH_B]  = ctrl_cd_r.pin_action_d;
      match_pri[compare_pkg::CH_C] = match[compare_pkg::CH_C] && own_c;
      code_pri[compare_pkg::CH_C]  = ctrl_cd_r.pin_action_c; // [R3]
      match_pri[compare_pkg::CH_D] = match[compare_pkg::CH_D] && own_d;
      code_pri[compare_pkg::CH_D]  = ctrl_cd_r.pin_action_d; // [R4]
      drive_en[compare_pkg::CH_A] = ctrl_ab_r.pin_action_a != compare_pkg::ACT_NONE ||
         (route_c_to_a && ctrl_cd_r.pin_action_c != compare_pkg::ACT_NONE); // [R1]
      drive_en[compare_pkg::CH_B] = ctrl_ab_r.pin_action_b != compare_pkg::ACT_NONE ||
         (route_d_to_b && ctrl_cd_r.pin_action_d != compare_pkg::ACT_NONE); // [R2]
      drive_en[compare_pkg::CH_C] = own_c && ctrl_cd_r.pin_action_c != compare_pkg::ACT_NONE; // [R3]
      drive_en[compare_pkg::CH_D] = own_d && ctrl_cd_r.pin_action_d != compare_pkg::ACT_NONE; // [R4]
   end

   // One pin unit per compare output
   for (genvar g = 0; g < NCH; g++) begin : g_pin
      pin_action_unit u_pin (
         .sys_clk_in   (sys_clk_in),
         .rst_b_in     (rst_b_in),
         .match_pri_in (match_pri[g]),
         .code_pri_in  (code_pri[g]),
         .match_sec_in (match_sec[g]),
         .code_sec_in  (code_sec[g]),
         .drive_en_in  (drive_en[g]),
         .level_out    (level[g]),
         .oe_out       (oe[g])
      );
   end

   assign compare_pin_a_out    = level[compare_pkg::CH_A];
   assign compare_pin_a_oe_out = oe[compare_pkg::CH_A];
   assign compare_pin_b_out    = level[compare_pkg::CH_B];
   assign compare_pin_b_oe_out = oe[compare_pkg::CH_B];
   assign compare_pin_c_out    = level[compare_pkg::CH_C];
   assign compare_pin_c_oe_out = oe[compare_pkg::CH_C];
   assign compare_pin_d_out    = level[compare_pkg::CH_D];
   assign compare_pin_d_oe_out = oe[compare_pkg::CH_D];

   // Checks
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);

   pin_a_low_a: assert property ( // [R1]
      match[compare_pkg::CH_A] && ctrl_ab_r.pin_action_a == compare_pkg::ACT_LOW
      |=> !compare_pin_a_out)
      else $error("pin A not low after match");

   pin_a_hold_a: assert property ( // [R1]
      !match_sec[compare_pkg::CH_A] && ctrl_ab_r.pin_action_a == compare_pkg::ACT_NONE
      |=> $stable(compare_pin_a_out))
      else $error("pin A moved with no action");

   pin_b_high_a: assert property ( // [R2]
      match[compare_pkg::CH_B] && ctrl_ab_r.pin_action_b == compare_pkg::ACT_HIGH
      |=> compare_pin_b_out)
      else $error("pin B not high after match");

   pin_c_toggle_a: assert property ( // [R3]
      match[compare_pkg::CH_C] && own_c && ctrl_cd_r.pin_action_c == compare_pkg::ACT_TOGGLE
      |=> compare_pin_c_out != $past(compare_pin_c_out))
      else $error("pin C did not toggle");

   pin_d_low_a: assert property ( // [R4]
      match[compare_pkg::CH_D] && own_d && ctrl_cd_r.pin_action_d == compare_pkg::ACT_LOW
      |=> !compare_pin_d_out)
      else $error("pin D not low after match");

   route_c_pin_a_a: assert property ( // [R7]
      !ctrl_cd_r.route_sel_c && !buffer_sel_c && !mode_sel[compare_pkg::CH_C] && count_en_in
      && count_value_in == cmp_r[compare_pkg::CH_C] && !match[compare_pkg::CH_A]
      && ctrl_cd_r.pin_action_c == compare_pkg::ACT_HIGH
      |=> compare_pin_a_out && $stable(compare_pin_c_out))
      else $error("C match did not drive pin A");

   route_d_pin_b_a: assert property ( // [R8]
      route_d_to_b && match[compare_pkg::CH_D] && !match[compare_pkg::CH_B]
      && ctrl_cd_r.pin_action_d == compare_pkg::ACT_LOW
      |=> !compare_pin_b_out ##1 !compare_pin_d_oe_out)
      else $error("D match did not drive pin B");

   fill_bit_a: assert property ( // [R11]
      bus_state_r == compare_pkg::BUS_IDLE && avmm_req_in.read && idx == compare_pkg::CTRL_AB_IDX
      |=> !avmm_waitrequest_out && avmm_readdata_out[7])
      else $error("unused control bit read as zero");

   buffer_load_a: assert property ( // [R15]
      buffer_sel_c && match[compare_pkg::CH_A]
      |=> cmp_r[compare_pkg::CH_A] == $past(cmp_r[compare_pkg::CH_C]) && !match[compare_pkg::CH_C])
      else $error("buffer value not transferred");

   bus_answer_a: assert property (
      avmm_waitrequest_out && (avmm_req_in.read || avmm_req_in.write)
      |=> !avmm_waitrequest_out ##1 avmm_waitrequest_out)
      else $error("bus answer not one cycle");

   toggle_a_cov: cover property (
      match[compare_pkg::CH_A] && ctrl_ab_r.pin_action_a == compare_pkg::ACT_TOGGLE);
   route_c_cov: cover property (match_sec[compare_pkg::CH_A]);
   buffer_cov: cover property (buffer_sel_d && match[compare_pkg::CH_B]);
   write_cov: cover property (wr_go && idx == compare_pkg::CTRL_CD_IDX);

endmodule // compare_match_pin_output_control

/* File: pin_load.sv */
/*
 * Load circuit on the four compare output pins, each with a weak pull-down.
 * Assumes pin levels and enables arrive from the compare block.
 */
module pin_load (
   input  wire logic [3:0] level_in,
   input  wire logic [3:0] oe_in,
   output logic      [3:0] sensed_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // Undriven pins fall to the pull-down level
   assign sensed_out = oe_in & level_in;
endmodule // pin_load

/* File: tb_top.sv */
/*
 * Self-checking bench: Avalon-MM register access, random counts, pin model.
 * Assumes the compare block and the pin load model are compiled before it.
 */
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic                   sys_clk_in = 1'b0;
   logic                   rst_b_in   = 1'b0;
   compare_pkg::avmm_req_t req        = '0;
   logic [31:0]            rdata;
   logic                   wait_req;
   logic [15:0]            cnt        = 16'h0000;
   logic                   cnt_en     = 1'b0;
   wire logic [3:0]        pin;
   wire logic [3:0]        oe;
   logic [3:0]             sensed;
   logic [3:0]             lv         = 4'h0;
   logic [3:0]             oe_x;
   logic [31:0]            q;
   logic [31:0]            w;
   int                     err_total  = 0;
   int                     n_compared = 0;
   int                     seed       = 32'h9F0447EA;
   int                     ab_m       = 32'h88;
   int                     cd_m       = 32'h88;
   int                     mode_m     = 0;
   int                     cmp_m[4]   = '{0, 0, 0, 0};
   bit                     chk_on     = 1'b0;

   always #4 sys_clk_in = ~sys_clk_in;

   compare_match_pin_output_control dut_u (
      .sys_clk_in          (sys_clk_in),
      .rst_b_in            (rst_b_in),
      .avmm_req_in         (req),
      .avmm_readdata_out   (rdata),
      .avmm_waitrequest_out(wait_req),
      .count_value_in      (cnt),
      .count_en_in         (cnt_en),
      .compare_pin_a_out   (pin[0]),
      .compare_pin_a_oe_out(oe[0]),
      .compare_pin_b_out   (pin[1]),
      .compare_pin_b_oe_out(oe[1]),
      .compare_pin_c_out   (pin[2]),
      .compare_pin_c_oe_out(oe[2]),
      .compare_pin_d_out   (pin[3]),
      .compare_pin_d_oe_out(oe[3])
   );

   pin_load load_u (
      .level_in  (pin),
      .oe_in     (oe),
      .sensed_out(sensed)
   );

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // One Avalon transfer, held until waitrequest is sampled low
   task automatic bus(input bit wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
      @(posedge sys_clk_in);
      req.read       <= !wr;
      req.write      <= wr;
      req.address    <= a;
      req.writedata  <= d;
      req.byteenable <= 4'hF;
      do begin
         @(posedge sys_clk_in);
      end while (wait_req !== 1'b0);
      rd = rdata;
      req.read  <= 1'b0;
      req.write <= 1'b0;
      if (wr)
         case (a)
            12'h490: ab_m = d;
            12'h494: cd_m = d;
            12'h4B0: mode_m = d & 3;
            default: if (a >= 12'h4A0 && a <= 12'h4AC) cmp_m[(a - 12'h4A0) / 4] = d & 16'hFFFF;
         endcase
   endtask

   function automatic int nib(int i);
      return ((i < 2 ? ab_m : cd_m) >> (4 * (i % 2))) & 15;
   endfunction

   function automatic logic app(logic l, int c);
      return c == 1 ? 1'b0 : c == 2 ? 1'b1 : c == 3 ? !l : l;
   endfunction

   // Reference pin model, stepped on the edge the design samples
   always @(posedge sys_clk_in) begin : model_p
      bit hit[4];
      int s;
      if (!rst_b_in) lv = 4'h0;
      else if (cnt_en) begin
         for (int i = 0; i < 4; i++) hit[i] = cnt == 16'(cmp_m[i]) && (nib(i) & 4) == 0;
         for (int p = 0; p < 2; p++) begin
            s = p + 2;
            if (hit[p] && (nib(p) & 3) != 0) lv[p] = app(lv[p], nib(p) & 3);
            else if (nib(s) < 8 && !mode_m[p] && hit[s]) lv[p] = app(lv[p], nib(s) & 3);
            if (nib(s) >= 8 && !mode_m[p] && hit[s]) lv[s] = app(lv[s], nib(s) & 3);
            if (mode_m[p] && hit[p]) cmp_m[p] = cmp_m[s];
         end
      end
   end

   always @(negedge sys_clk_in)
      if (chk_on) begin
         for (int p = 0; p < 2; p++) begin
            oe_x[p] = (nib(p) & 3) != 0 ||
               (nib(p + 2) < 8 && !mode_m[p] && (nib(p + 2) & 3) != 0);
            oe_x[p + 2] = nib(p + 2) >= 8 && !mode_m[p] && (nib(p + 2) & 3) != 0;
         end
         chk(32'(pin), 32'(lv));
         chk(32'(oe), 32'(oe_x));
         chk(32'(sensed), 32'(oe_x & lv));
      end

   initial begin
      #(8 * 20000);
      err_total++;
      wrap_up();
   end

   initial begin
      repeat (2) @(posedge sys_clk_in);
      rst_b_in <= 1'b1;
      bus(0, 12'h490, 32'h0, q);
      chk(q, 32'h88);
      bus(0, 12'h494, 32'h0, q);
      chk(q, 32'h88);
      bus(1, 12'h7FC, 32'hFF, q);
      bus(0, 12'h7FC, 32'h0, q);
      chk(q, 32'h0);
      for (int r = 0; r < 2; r++)
         for (int b = 0; b < 2; b++)
            for (int c = 0; c < 4; c++) begin
               @(posedge sys_clk_in);
               cnt_en <= 1'b0;
               chk_on = 1'b0;
               for (int i = 0; i < 4; i++) begin
                  w = $random(seed);
                  bus(1, 12'(12'h4A0 + 4 * i), (i == 2 && w[20]) ? 32'(cmp_m[0]) : 32'(w[15:0]), q);
               end
               bus(1, 12'h4B0, b ? 32'h3 : 32'h0, q);
               bus(1, 12'h490, 32'(8 | c | ((c ^ 1) << 4)), q);
               bus(1, 12'h494, 32'(r * 8 | (c + 1) % 4 | ((r * 8 | (3 - c)) << 4)), q);
               bus(0, 12'h490, 32'h0, q);
               chk(q, 32'(8'h88 | c | ((c ^ 1) << 4)));
               repeat (2) @(posedge sys_clk_in);
               chk_on = 1'b1;
               repeat (40) begin
                  @(posedge sys_clk_in);
                  w = $random(seed);
                  cnt    <= w[3] ? 16'(cmp_m[w[1:0]]) : w[31:16];
                  cnt_en <= w[2] | w[4];
               end
            end
      @(posedge sys_clk_in);
      cnt_en <= 1'b0;
      chk_on = 1'b0;
      bus(0, 12'h4B4, 32'h0, q);
      chk(32'(q[7:0]), 32'({oe_x, lv}));
      wrap_up();
   end
endmodule // tb_top
